// ===== src/jtp_tap.sv
/*
 Test access port: controller, instruction and data registers on the test
 clock, serial output on its falling edge, and a user word exchanged with
 the clock domain by toggle handshakes.
 Assumes the test clock period is at least four clock periods.
*/
`timescale 1ns/1ps
module jtp_tap
   import jtp_pkg::*;
#(
   // Value is arbitrary; bit 0 kept at one
   parameter logic [31:0] ID_CODE = 32'h00000001
)
(
   // System side
   input  wire logic     clock,
   input  wire logic     rst,
   // Test pins
   input  wire logic     tck,
   input  wire logic     tms,
   input  wire logic     tdi,
   input  wire logic     trst_n,
   output logic          tdo,
   output logic          tdo_oe,
   // User word
   input  wire logic [31:0] user_cap,
   output jtp_upd_t      upd
);

   // Port reset: pin reset or system reset, both asynchronous
   logic            tap_rst;
   assign tap_rst = rst | ~trst_n;

   jtp_state_t      state;
   jtp_state_t      next_state;
   logic [IR_W-1:0] ir;
   logic [IR_W-1:0] next_ir;
   logic [IR_W-1:0] ir_sh;
   logic [IR_W-1:0] next_ir_sh;
   logic [DR_W-1:0] dr_sh;
   logic [DR_W-1:0] next_dr_sh;
   logic            byp;
   logic            next_byp;
   logic [DR_W-1:0] upd_word;
   logic [DR_W-1:0] next_upd_word;
   logic            upd_tgl;
   logic            next_upd_tgl;
   logic            snap_tgl;
   logic            next_snap_tgl;
   logic            next_tdo;
   logic            next_tdo_oe;

   // Clock-domain side
   logic [DR_W-1:0] cap_word;
   logic [DR_W-1:0] next_cap_word;
   logic            snap_s;
   logic            snap_p;
   logic            upd_s;
   logic            upd_p;
   jtp_upd_t        next_upd;

   // Test clock, rising edge
   always_comb
   begin
      next_state    = jtp_next(state, tms);
      next_ir       = ir;
      next_ir_sh    = ir_sh;
      next_dr_sh    = dr_sh;
      next_byp      = byp;
      next_upd_word = upd_word;
      next_upd_tgl  = upd_tgl;
      next_snap_tgl = snap_tgl;
      if (next_state == SEL_DR && state != SEL_DR)
      begin
         // Ask the clock side to refresh its snapshot
         next_snap_tgl = ~snap_tgl;
      end
      unique case (state)
         TLR:
         begin
            // default instruction while in reset state
            next_ir = IR_IDCODE;
         end
         CAP_IR:
         begin
            next_ir_sh = IR_CAPTURE;
         end
         SH_IR:
         begin
            // data in taken on rising edge
            next_ir_sh = {tdi, ir_sh[IR_W-1:1]};
         end
         UPD_IR:
         begin
            next_ir = ir_sh;
         end
         CAP_DR:
         begin
            next_byp = 1'b0;
            if (ir == IR_IDCODE)
            begin
               next_dr_sh = ID_CODE;
            end
            else if (ir == IR_USER)
            begin
               // Snapshot stable since the handshake settled
               next_dr_sh = cap_word;
            end
         end
         SH_DR:
         begin
            // data in taken on rising edge
            if (ir == IR_IDCODE || ir == IR_USER)
            begin
               next_dr_sh = {tdi, dr_sh[DR_W-1:1]};
            end
            else
            begin
               next_byp = tdi;
            end
         end
         UPD_DR:
         begin
            if (ir == IR_USER)
            begin
               next_upd_word = dr_sh;
               next_upd_tgl  = ~upd_tgl;
            end
         end
         default:
         begin
         end
      endcase
   end

   // pin reset acts without the test clock
   // five high mode-select edges reach reset without the pin
   always_ff @(posedge tck or posedge tap_rst)
   begin
      if (tap_rst)
      begin
         state    <= TLR;
         ir       <= IR_IDCODE;
         ir_sh    <= IR_CAPTURE;
         dr_sh    <= WORD_RESET;
         byp      <= 1'b0;
      end
      else
      begin
         state    <= next_state;
         ir       <= next_ir;
         ir_sh    <= next_ir_sh;
         dr_sh    <= next_dr_sh;
         byp      <= next_byp;
      end
   end

   // Handshake toggles ignore the pin reset: no false update strobe
   always_ff @(posedge tck or posedge rst)
   begin
      if (rst)
      begin
         upd_word <= WORD_RESET;
         upd_tgl  <= TGL_RESET;
         snap_tgl <= TGL_RESET;
      end
      else
      begin
         upd_word <= next_upd_word;
         upd_tgl  <= next_upd_tgl;
         snap_tgl <= next_snap_tgl;
      end
   end

   // Test clock, falling edge
   always_comb
   begin
      next_tdo_oe = jtp_shifting(state);
      next_tdo    = 1'b0;
      if (state == SH_IR)
      begin
         next_tdo = ir_sh[0];
      end
      else if (state == SH_DR)
      begin
         next_tdo = (ir == IR_IDCODE || ir == IR_USER) ? dr_sh[0] : byp;
      end
   end

   // output bit changes on falling edge
   always_ff @(negedge tck or posedge tap_rst)
   begin
      if (tap_rst)
      begin
         tdo    <= 1'b0;
         tdo_oe <= 1'b0;
      end
      else
      begin
         tdo    <= next_tdo;
         tdo_oe <= next_tdo_oe;
      end
   end

   // Crossing into the clock domain
   jtp_sync u_snap_sync
   (
      .clock (clock),
      .rst   (rst),
      .d     (snap_tgl),
      .q     (snap_s)
   );

   jtp_sync u_upd_sync
   (
      .clock (clock),
      .rst   (rst),
      .d     (upd_tgl),
      .q     (upd_s)
   );

   always_comb
   begin
      next_cap_word = cap_word;
      next_upd      = '{valid: 1'b0, data: upd.data};
      if (snap_s != snap_p)
      begin
         next_cap_word = user_cap;
      end
      if (upd_s != upd_p)
      begin
         // Word held steady in the test domain until the next update
         next_upd = '{valid: 1'b1, data: upd_word};
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         cap_word <= WORD_RESET;
         snap_p   <= TGL_RESET;
         upd_p    <= TGL_RESET;
         upd      <= '{valid: 1'b0, data: WORD_RESET};
      end
      else
      begin
         cap_word <= next_cap_word;
         snap_p   <= snap_s;
         upd_p    <= upd_s;
         upd      <= next_upd;
      end
   end

   // Checks
   sequence s_cap_ir;
      state == CAP_IR;
   endsequence

   sequence s_shift_ir_in;
      state == SH_IR;
   endsequence

   sequence s_five_high;
      tms [*5];
   endsequence

   a_ir_capture_value: assert property (
      @(posedge tck) disable iff (tap_rst)
      s_cap_ir |=> (ir_sh == IR_CAPTURE))
      else $error("capture pattern not loaded");

   a_tdi_shift_in: assert property (
      @(posedge tck) disable iff (tap_rst)
      s_shift_ir_in |=> (ir_sh[IR_W-1] == $past(tdi)))
      else $error("data in not taken on rising edge");

   a_tdo_ir_bit: assert property (
      @(posedge tck) disable iff (tap_rst)
      (state == SH_IR) && $past(state == SH_IR) |-> (tdo == ir_sh[0]))
      else $error("output bit not from instruction shift");

   a_tdo_float: assert property (
      @(posedge tck) disable iff (tap_rst)
      tdo_oe == jtp_shifting(state))
      else $error("output enable wrong for state");

   a_tms_steers: assert property (
      @(posedge tck) disable iff (tap_rst)
      (state == RTI) |=> (state == ($past(tms) ? SEL_DR : RTI)))
      else $error("controller ignored mode select");

   a_pin_reset_async: assert property (
      @(posedge clock) disable iff (rst)
      !trst_n |-> (state == TLR) && (ir == IR_IDCODE) && !tdo_oe)
      else $error("port not held in reset");

   a_five_high_reset: assert property (
      @(posedge tck) disable iff (tap_rst)
      s_five_high |=> (state == TLR))
      else $error("five high edges did not reach reset");

   a_default_instr: assert property (
      @(posedge tck) disable iff (tap_rst)
      (state == TLR) |=> (ir == IR_IDCODE))
      else $error("default instruction not loaded");

   a_update_pulse: assert property (
      @(posedge clock) disable iff (rst)
      upd.valid |=> !upd.valid)
      else $error("update strobe longer than one cycle");

endmodule

// ===== src/jtp_pkg.sv
/*
 Constants, types and state decoding for the test access port.
 Assumes the port logic runs on the test clock and the user side on clock.
*/
// Operation
// - Serial input bits are taken from the data input on the rising clock edge.
// - The serial output takes each next bit on the falling clock edge.
// - The serial output floats whenever nothing is being shifted out.
// - Mode select is sampled on the rising edge and advances the controller.
// - Test reset low resets the port logic at once, without a clock edge, except the handshake toggles and update word.
// - The port works fully with only clock, mode select, data in and out.
package jtp_pkg;

   localparam int          IR_W        = 4;
   localparam int          DR_W        = 32;
   localparam logic [3:0]  IR_CAPTURE  = 4'h1;
   localparam logic [3:0]  IR_IDCODE   = 4'h2;
   localparam logic [3:0]  IR_USER     = 4'h8;
   localparam logic [3:0]  IR_BYPASS   = 4'hF;
   localparam logic [31:0] WORD_RESET  = 32'h00000000;
   localparam logic        TGL_RESET   = 1'b0;

   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
   } jtp_state_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] data;
   } jtp_upd_t;

   // Controller transition on one rising edge
   function automatic jtp_state_t jtp_next(jtp_state_t s, logic m);
      jtp_state_t n;
      n = TLR;
      unique case (s)
         TLR:    n = m ? TLR    : RTI;
         RTI:    n = m ? SEL_DR : RTI;
         SEL_DR: n = m ? SEL_IR : CAP_DR;
         CAP_DR: n = m ? EX1_DR : SH_DR;
         SH_DR:  n = m ? EX1_DR : SH_DR;
         EX1_DR: n = m ? UPD_DR : PA_DR;
         PA_DR:  n = m ? EX2_DR : PA_DR;
         EX2_DR: n = m ? UPD_DR : SH_DR;
         UPD_DR: n = m ? SEL_DR : RTI;
         SEL_IR: n = m ? TLR    : CAP_IR;
         CAP_IR: n = m ? EX1_IR : SH_IR;
         SH_IR:  n = m ? EX1_IR : SH_IR;
         EX1_IR: n = m ? UPD_IR : PA_IR;
         PA_IR:  n = m ? EX2_IR : PA_IR;
         EX2_IR: n = m ? UPD_IR : SH_IR;
         UPD_IR: n = m ? SEL_DR : RTI;
      endcase
      return n;
   endfunction

   function automatic logic jtp_shifting(jtp_state_t s);
      return (s == SH_DR) || (s == SH_IR);
   endfunction

endpackage

// ===== src/jtp_sync.sv
/*
 Two-stage synchroniser for one level into the clock domain.
 Assumes the input changes no faster than twice per three clock periods.
*/
`timescale 1ns/1ps
module jtp_sync
   import jtp_pkg::*;
(
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst,
   // Level in and out
   input  wire logic d,
   output logic      q
);

   logic meta;
   logic next_meta;
   logic next_q;

   always_comb
   begin
      next_meta = d;
      next_q    = meta;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         meta <= TGL_RESET;
         q    <= TGL_RESET;
      end
      else
      begin
         meta <= next_meta;
         q    <= next_q;
      end
   end

endmodule

// ===== tb/jtp_host.sv
/*
 Behavioural test host that drives the test pins of the port.
 Assumes a 48 ns test clock that stands still low between frames.
*/
`timescale 1ns/1ps
module jtp_host
(
   // Test pins toward the port
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   output logic      trst_n,
   // Serial return
   input  wire logic tdo,
   input  wire logic tdo_oe
);
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
      trst_n = 1'b0;
   end

   // One test clock period; return bit sampled before the rise
   task automatic step(input logic m, input logic d, output logic so,
                       output logic soe);
      tms = m;
      tdi = d;
      #12;
      so = tdo;
      soe = tdo_oe;
      tck = 1'b1;
      #24;
      tck = 1'b0;
      #12;
   endtask

   // Test reset with the clock held still
   task automatic hold_trst();
      trst_n = 1'b0;
      #20;
   endtask

   task automatic release_trst();
      tms = 1'b1;
      #10;
      trst_n = 1'b1;
      #10;
   endtask

   // Full scan from idle back to idle; idle data line pulled high
   task automatic scan(input logic ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout, output logic oe_on,
                       output logic oe_off);
      logic so;
      logic soe;
      dout = 32'h00000000;
      oe_on = 1'b1;
      oe_off = 1'b0;
      step(1'b1, 1'b1, so, soe);
      oe_off |= soe;
      if (ir)
         step(1'b1, 1'b1, so, soe);
      step(1'b0, 1'b1, so, soe);
      oe_off |= soe;
      step(1'b0, 1'b1, so, soe);
      oe_off |= soe;
      for (int i = 0; i < n; i++)
      begin
         step(i == n - 1, din[i], so, soe);
         dout[i] = so;
         oe_on &= soe;
      end
      step(1'b1, 1'b1, so, soe);
      oe_off |= soe;
      step(1'b0, 1'b1, so, soe);
      oe_off |= soe;
   endtask
endmodule

// ===== tb/testbench.sv
/*
 Self-checking bench for the test access port.
 Assumes the host model drives the test pins and the bench the clock side.
*/
`timescale 1ns/1ps
module testbench;
   import jtp_pkg::*;

   // Value is arbitrary; bit 0 kept at one
   localparam logic [31:0] ID   = 32'h0000ACE1;
   localparam logic [31:0] CAPW = 32'hA5C31E7F;
   localparam logic [31:0] UPW  = 32'h3C960F5A;

   logic        clock;
   logic        rst;
   logic        tck;
   logic        tms;
   logic        tdi;
   logic        trst_n;
   logic        tdo;
   logic        tdo_oe;
   logic [31:0] user_cap;
   jtp_upd_t    upd;
   int          errors = 0;
   int          total_checks = 0;
   int          upd_cnt = 0;
   logic [31:0] upd_word;
   logic [31:0] d;
   logic        on;
   logic        off;
   logic        so;
   logic        soe;

   jtp_tap #(.ID_CODE(ID)) u_jtp_tap (.clock(clock), .rst(rst), .tck(tck),
      .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe),
      .user_cap(user_cap), .upd(upd));

   jtp_host u_jtp_host (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
      .tdo(tdo), .tdo_oe(tdo_oe));

   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Counts update pulses seen on the clock side
   always @(posedge clock)
      if (upd.valid === 1'b1)
      begin
         upd_cnt <= upd_cnt + 1;
         upd_word <= upd.data;
      end

   task automatic wrap_up();
      if (errors == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp,
                        input string what);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic load_ir(input logic [3:0] code);
      u_jtp_host.scan(1'b1, 4, {28'h0000000, code}, d, on, off);
      check({28'h0000000, d[3:0]}, 32'h00000001, "ir capture");
   endtask

   task automatic sc_idcode();
      u_jtp_host.step(1'b0, 1'b1, so, soe);
      u_jtp_host.scan(1'b0, 32, 32'h00000000, d, on, off);
      check(d, ID, "default id");
      check({31'h0, on}, 32'h1, "enable in shift");
      check({31'h0, off}, 32'h0, "enable outside shift");
   endtask

   task automatic sc_user();
      int n0;
      load_ir(IR_USER);
      n0 = upd_cnt;
      u_jtp_host.scan(1'b0, 32, UPW, d, on, off);
      check(d, CAPW, "user capture");
      for (int i = 0; i < 40 && upd_cnt == n0; i++)
         @(posedge clock);
      check(upd_cnt - n0, 1, "update count");
      check(upd_word, UPW, "user update");
      if (upd_cnt == n0)
         wrap_up();
   endtask

   task automatic sc_bypass();
      load_ir(IR_BYPASS);
      u_jtp_host.scan(1'b0, 8, 32'h000000B6, d, on, off);
      check({24'h0, d[7:0]}, 32'h0000006C, "bypass path");
   endtask

   task automatic sc_trst();
      int n0;
      load_ir(IR_USER);
      n0 = upd_cnt;
      u_jtp_host.step(1'b1, 1'b1, so, soe);
      u_jtp_host.step(1'b0, 1'b1, so, soe);
      u_jtp_host.step(1'b0, 1'b1, so, soe);
      u_jtp_host.step(1'b0, 1'b0, so, soe);
      check({31'h0, tdo_oe}, 32'h1, "mid scan enable");
      u_jtp_host.hold_trst();
      check({30'h0, tdo, tdo_oe}, 32'h0, "async test reset");
      u_jtp_host.release_trst();
      u_jtp_host.step(1'b0, 1'b1, so, soe);
      u_jtp_host.scan(1'b0, 32, 32'h00000000, d, on, off);
      check(d, ID, "id after test reset");
      check(upd_cnt - n0, 0, "no update from test reset");
   endtask

   task automatic sc_no_trst();
      load_ir(IR_USER);
      for (int i = 0; i < 5; i++)
         u_jtp_host.step(1'b1, 1'b1, so, soe);
      u_jtp_host.step(1'b0, 1'b1, so, soe);
      u_jtp_host.scan(1'b0, 32, 32'h00000000, d, on, off);
      check(d, ID, "id after mode reset");
   endtask

   initial
   begin
      rst = 1'b1;
      user_cap = CAPW;
      repeat (3) @(posedge clock);
      #1 rst = 1'b0;
      u_jtp_host.release_trst();
      sc_idcode();
      sc_user();
      sc_bypass();
      sc_trst();
      sc_no_trst();
      wrap_up();
   end
endmodule
